// ### hdl/fmpc_pkg.sv
// Shared constants and types for the fault mask and phase config block
package fmpc_pkg;

  // Structure sizes
  localparam int unsigned PHASES  = 6;
  localparam int unsigned ALERT_W = 18;
  localparam int unsigned TRIP_W  = 16;
  localparam int unsigned PINS    = 12;

  // Serial slave address, lsb comes from the strap pin
  localparam logic [6:0] SLAVE_BASE = 7'h70;

  // Register word addresses on the serial bus
  localparam logic [15:0] OFS_MODE    = 16'h0100;
  localparam logic [15:0] OFS_ALRTA_L = 16'h0102;
  localparam logic [15:0] OFS_ALRTA_H = 16'h0103;
  localparam logic [15:0] OFS_ALRTB_L = 16'h0104;
  localparam logic [15:0] OFS_ALRTB_H = 16'h0105;
  localparam logic [15:0] OFS_TRIP    = 16'h0106;
  localparam logic [15:0] OFS_PHASE   = 16'h0107;
  localparam logic [15:0] OFS_PINMAP  = 16'h0108;
  localparam logic [15:0] OFS_STATUS  = 16'h0109;

  // Values after reset
  localparam logic               MODE_RST   = 1'b0;
  localparam logic [ALERT_W-1:0] ALERT_RST  = 18'h00000;
  localparam logic [TRIP_W-1:0]  TRIP_RST   = 16'h0000;
  localparam logic [PHASES-1:0]  PHASE_RST  = 6'h3f;
  localparam logic               PINMAP_RST = 1'b0;

  // Mask positions that carry a fault source
  localparam logic [ALERT_W-1:0] ALERT_USED = 18'h3ffbb;
  localparam logic [TRIP_W-1:0]  TRIP_USED  = 16'hfff7;

  // Alert mask field positions
  localparam int unsigned AB_NVM   = 17;
  localparam int unsigned AB_IBUS  = 16;
  localparam int unsigned AB_INUV  = 15;
  localparam int unsigned AB_OUTUV = 14;
  localparam int unsigned AB_OUTOV = 13;
  localparam int unsigned AB_THALR = 12;
  localparam int unsigned AB_THSHD = 11;
  localparam int unsigned AB_DIALR = 10;
  localparam int unsigned AB_DISHD = 9;
  localparam int unsigned AB_HS1   = 8;
  localparam int unsigned AB_HS2   = 7;
  localparam int unsigned AB_HS3   = 5;
  localparam int unsigned AB_HS5   = 4;
  localparam int unsigned AB_HS6   = 3;
  localparam int unsigned AB_CLK   = 1;
  localparam int unsigned AB_CAL   = 0;

  // Trip mask field positions; high-side shorts run 8 down to 4
  localparam int unsigned TB_INUV  = 15;
  localparam int unsigned TB_OUTUV = 14;
  localparam int unsigned TB_OUTOV = 13;
  localparam int unsigned TB_PHREG = 12;
  localparam int unsigned TB_THSHD = 11;
  localparam int unsigned TB_PHSS  = 10;
  localparam int unsigned TB_DISHD = 9;
  localparam int unsigned TB_HS1   = 8;
  localparam int unsigned TB_TOREG = 2;
  localparam int unsigned TB_TOSS  = 1;
  localparam int unsigned TB_CAL   = 0;

  // Raw fault sources; hs_short index 0 is channel 1
  typedef struct packed {
    logic              nvm;
    logic              int_bus;
    logic              in_uv;
    logic              out_uv;
    logic              out_ov;
    logic              therm_alert;
    logic              therm_shdn;
    logic              die_alert;
    logic              die_shdn;
    logic [PHASES-1:0] hs_short;
    logic              clk_ctrl;
    logic              calib;
    logic              phase_oc_reg;
    logic              phase_oc_ss;
    logic              total_oc_reg;
    logic              total_oc_ss;
  } fmpc_fault_t;

  // Serial bit engine states
  typedef enum logic [2:0] {
    BIT_IDLE,
    BIT_RX,
    BIT_ACK,
    BIT_TX,
    BIT_TXACK
  } fmpc_bit_state_t;

endpackage

// ### hdl/fmpc_serial_bits.sv
// Two-wire serial slave bit and byte engine
`timescale 1ns/10ps
module fmpc_serial_bits
  import fmpc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] dev_addr,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output      logic       sda_out,
  output      logic       sda_oe,
  output      logic       bus_start,
  output      logic       bus_stop,
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  output      logic       tx_req,
  input  wire logic [7:0] tx_data
);

  fmpc_bit_state_t state;     // Bit engine state
  logic            scl_q;     // Previous clock line
  logic            sda_q;     // Previous data line
  logic [2:0]      cnt;       // Bit count in byte
  logic [7:0]      sh;        // Shift register
  logic            first;     // Address byte in progress
  logic            rw;        // Read requested
  logic            byte_done; // Eighth bit seen
  logic            more;      // Master acked a read byte
  logic            start_c;
  logic            stop_c;
  logic            rise;
  logic            fall;
  logic            hit;

  // Lines are already synchronous, one stage for edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c  = scl_in & scl_q & ~sda_q & sda_in;
  assign rise    = scl_in & ~scl_q;
  assign fall    = ~scl_in & scl_q;
  assign hit     = (sh[7:1] == dev_addr);

  // Byte framing, acknowledge and read shifting
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state     <= BIT_IDLE;
      cnt       <= 3'h0;
      sh        <= 8'h00;
      first     <= 1'b0;
      rw        <= 1'b0;
      byte_done <= 1'b0;
      more      <= 1'b0;
    end else if (start_c) begin
      // Repeated start restarts framing anywhere
      state     <= BIT_RX;
      cnt       <= 3'h0;
      first     <= 1'b1;
      byte_done <= 1'b0;
    end else if (stop_c) begin
      state <= BIT_IDLE;
    end else begin
      case (state)
        BIT_RX: begin
          if (rise) begin
            sh        <= {sh[6:0], sda_in};
            cnt       <= cnt + 3'h1;
            byte_done <= (cnt == 3'h7);
          end else if (fall && byte_done) begin
            byte_done <= 1'b0;
            // Foreign address: stay off the bus till next start
            state     <= (!first || hit) ? BIT_ACK : BIT_IDLE;
            if (first) begin
              rw <= sh[0];
            end
          end
        end
        BIT_ACK: begin
          if (fall) begin
            first <= 1'b0;
            cnt   <= 3'h0;
            if (rw) begin
              state <= BIT_TX;
              sh    <= tx_data;
            end else begin
              state <= BIT_RX;
            end
          end
        end
        BIT_TX: begin
          if (fall) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
              state <= BIT_TXACK;
            end else begin
              sh <= {sh[6:0], 1'b0};
            end
          end
        end
        BIT_TXACK: begin
          if (rise) begin
            more <= ~sda_in;
          end else if (fall) begin
            // Not-acknowledge ends the read and frees the line
            state <= more ? BIT_TX : BIT_IDLE;
            sh    <= tx_data;
            cnt   <= 3'h0;
          end
        end
        default: begin
          state <= BIT_IDLE;
        end
      endcase
    end
  end

  // One-cycle event pulses towards the register side
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_start <= 1'b0;
      bus_stop  <= 1'b0;
      rx_valid  <= 1'b0;
      tx_req    <= 1'b0;
    end else begin
      bus_start <= start_c;
      bus_stop  <= stop_c;
      rx_valid  <= !start_c && !stop_c && state == BIT_RX && fall
                   && byte_done && !first;
      tx_req    <= !start_c && !stop_c
                   && ((state == BIT_RX && fall && byte_done && first
                        && hit && sh[0])
                       || (state == BIT_TXACK && rise && !sda_in));
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = (state == BIT_ACK) || (state == BIT_TX && !sh[7]);
  assign rx_data = sh;

endmodule

// ### hdl/fmpc_fault_mask_phase_config.sv
// Fault masking, trip, phase enable and drive pin mapping with registers
`timescale 1ns/10ps
module fmpc_fault_mask_phase_config
  import fmpc_pkg::*;
#(
  parameter int unsigned N_PHASE = PHASES
)(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               addr_strap,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output      logic               sda_out,
  output      logic               sda_oe,
  input  wire fmpc_fault_t        fault,
  input  wire logic [N_PHASE-1:0] pwm_in,
  input  wire logic [N_PHASE-1:0] low_side_gate_signal,
  output      logic               alert_a,
  output      logic               alert_b,
  output      logic               trip,
  output      logic [N_PHASE-1:0] phase_enable,
  output      logic [PINS-1:0]    drive_pin
);

  // Pin mapping is fixed at two pins per phase
  if (N_PHASE != PHASES) begin : g_bad_phase
    $error("N_PHASE must equal the six supported phases");
  end

  logic               driver_mode_select;  // 1 = dual input drivers
  logic [ALERT_W-1:0] alert_pin_a_enables; // Alert pin A sources
  logic [ALERT_W-1:0] alert_pin_b_enables; // Alert pin B sources
  logic [TRIP_W-1:0]  trip_enable_set;     // Shutdown sources
  logic [PHASES-1:0]  active_phase_select; // Bit 0 is phase one
  logic               pin_map_select;      // Output pin routing

  logic               bus_start;
  logic               bus_stop;
  logic               rx_valid;
  logic [7:0]         rx_data;
  logic               tx_req;
  logic [7:0]         tx_data;   // Byte handed to the serial engine
  logic [2:0]         byte_idx;  // Bytes since start, saturates
  logic [15:0]        reg_addr;  // Current register address
  logic [7:0]         data_hi;   // First data byte of a write
  logic [7:0]         rd_hold;   // Low byte captured with high byte
  logic               rd_lo;     // Next read byte is the low one
  logic               wr_stb;
  logic [15:0]        wr_word;
  logic [15:0]        rd_word;
  logic [ALERT_W-1:0] alert_src;
  logic [TRIP_W-1:0]  trip_src;
  logic               phase_ok;  // Selector is a legal contiguous set
  logic [PHASES-1:0]  hs_q;      // Gated high-side signals
  logic [PHASES-1:0]  ls_q;      // Gated low-side signals
  logic [PINS-1:0]    next_pin;

  // All checks run on the core clock and rest during reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Serial bit engine
  fmpc_serial_bits fmpc_serial_bits_inst (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .dev_addr  ({SLAVE_BASE[6:1], addr_strap}),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .bus_start (bus_start),
    .bus_stop  (bus_stop),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .tx_req    (tx_req),
    .tx_data   (tx_data)
  );

  // byte sequencing: address high, address low, data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      byte_idx <= 3'h0;
      reg_addr <= 16'h0000;
      data_hi  <= 8'h00;
    end else if (bus_start || bus_stop) begin
      byte_idx <= 3'h0;
    end else if (rx_valid) begin
      // Bytes past the fourth are acked but ignored
      if (byte_idx != 3'h4) begin
        byte_idx <= byte_idx + 3'h1;
      end
      case (byte_idx)
        3'h0: reg_addr[15:8] <= rx_data;
        3'h1: reg_addr[7:0]  <= rx_data;
        3'h2: data_hi        <= rx_data;
        default: ;
      endcase
    end
  end

  assign wr_stb  = rx_valid && byte_idx == 3'h3;
  assign wr_word = {data_hi, rx_data};

  // Configuration register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      driver_mode_select  <= MODE_RST;
      alert_pin_a_enables <= ALERT_RST;
      alert_pin_b_enables <= ALERT_RST;
      trip_enable_set     <= TRIP_RST;
      active_phase_select <= PHASE_RST;
      pin_map_select      <= PINMAP_RST;
    end else if (wr_stb) begin
      // Unmapped addresses take no effect
      case (reg_addr)
        OFS_MODE:    driver_mode_select <= wr_word[0];
        OFS_ALRTA_L: alert_pin_a_enables[15:0] <= wr_word;
        OFS_ALRTA_H: alert_pin_a_enables[17:16] <= wr_word[1:0];
        OFS_ALRTB_L: alert_pin_b_enables[15:0] <= wr_word;
        OFS_ALRTB_H: alert_pin_b_enables[17:16] <= wr_word[1:0];
        OFS_TRIP:    trip_enable_set <= wr_word;
        OFS_PHASE:   active_phase_select <= wr_word[5:0];
        OFS_PINMAP:  pin_map_select <= wr_word[0];
        default: ;
      endcase
    end
  end

  // Read data; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      OFS_MODE:    rd_word = {15'h0000, driver_mode_select};
      OFS_ALRTA_L: rd_word = alert_pin_a_enables[15:0];
      OFS_ALRTA_H: rd_word = {14'h0000, alert_pin_a_enables[17:16]};
      OFS_ALRTB_L: rd_word = alert_pin_b_enables[15:0];
      OFS_ALRTB_H: rd_word = {14'h0000, alert_pin_b_enables[17:16]};
      OFS_TRIP:    rd_word = trip_enable_set;
      OFS_PHASE:   rd_word = {10'h000, active_phase_select};
      OFS_PINMAP:  rd_word = {15'h0000, pin_map_select};
      OFS_STATUS:  rd_word = {12'h000, phase_ok, trip, alert_b, alert_a};
      default:     rd_word = 16'h0000;
    endcase
  end

  // read bytes: high first, low held from the same instant
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_data <= 8'h00;
      rd_hold <= 8'h00;
      rd_lo   <= 1'b0;
    end else if (bus_start) begin
      rd_lo <= 1'b0;
    end else if (tx_req) begin
      // Holding the low byte keeps the word coherent across bytes
      tx_data <= rd_lo ? rd_hold : rd_word[15:8];
      rd_hold <= rd_word[7:0];
      rd_lo   <= ~rd_lo;
    end
  end

  always_comb begin
    alert_src           = '0;
    alert_src[AB_NVM]   = fault.nvm;
    alert_src[AB_IBUS]  = fault.int_bus;
    alert_src[AB_INUV]  = fault.in_uv;
    alert_src[AB_OUTUV] = fault.out_uv;
    alert_src[AB_OUTOV] = fault.out_ov;
    alert_src[AB_THALR] = fault.therm_alert;
    alert_src[AB_THSHD] = fault.therm_shdn;
    alert_src[AB_DIALR] = fault.die_alert;
    alert_src[AB_DISHD] = fault.die_shdn;
    alert_src[AB_HS1]   = fault.hs_short[0];
    alert_src[AB_HS2]   = fault.hs_short[1];
    alert_src[AB_HS3]   = fault.hs_short[2];
    alert_src[AB_HS5]   = fault.hs_short[4];
    alert_src[AB_HS6]   = fault.hs_short[5];
    alert_src[AB_CLK]   = fault.clk_ctrl;
    alert_src[AB_CAL]   = fault.calib;
  end

  always_comb begin
    trip_src           = '0;
    trip_src[TB_INUV]  = fault.in_uv;
    trip_src[TB_OUTUV] = fault.out_uv;
    trip_src[TB_OUTOV] = fault.out_ov;
    trip_src[TB_PHREG] = fault.phase_oc_reg;
    trip_src[TB_THSHD] = fault.therm_shdn;
    trip_src[TB_PHSS]  = fault.phase_oc_ss;
    trip_src[TB_DISHD] = fault.die_shdn;
    // Channel six short has no trip position
    for (int i = 0; i < 5; i++) begin
      trip_src[TB_HS1 - i] = fault.hs_short[i];
    end
    trip_src[TB_TOREG] = fault.total_oc_reg;
    trip_src[TB_TOSS]  = fault.total_oc_ss;
    trip_src[TB_CAL]   = fault.calib;
  end

  // masked OR, registered to give clean pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_a <= 1'b0;
      alert_b <= 1'b0;
      trip    <= 1'b0;
    end else begin
      // unused positions are gated out again
      alert_a <= |(alert_pin_a_enables & ALERT_USED & alert_src);
      alert_b <= |(alert_pin_b_enables & ALERT_USED & alert_src);
      trip    <= |(trip_enable_set & TRIP_USED & trip_src);
    end
  end

  // Legal selector: low two bits set, no gaps above
  assign phase_ok = (active_phase_select[1:0] == 2'h3)
    && ((active_phase_select & (active_phase_select + 6'h01)) == 6'h00);
  assign phase_enable = active_phase_select;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hs_q <= '0;
      ls_q <= '0;
    end else begin
      // A gap from a bad selector is served as written, not fixed
      hs_q <= pwm_in & active_phase_select;
      ls_q <= driver_mode_select
              ? (low_side_gate_signal & active_phase_select) : '0;
    end
  end

  // pin routing: interleaved pairs or split halves
  for (genvar i = 0; i < PINS; i++) begin : g_map
    logic paired; // Map 0: even pin high side, odd pin low side
    logic split;  // Map 1: first half high side, second half low
    assign paired = (i % 2 == 0) ? hs_q[i / 2] : ls_q[i / 2];
    assign split  = (i < PHASES) ? hs_q[i % PHASES] : ls_q[i % PHASES];
    assign next_pin[i] = pin_map_select ? split : paired;
  end

  // Drive pins come straight from flops; index 0 is drive_pin_first
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drive_pin <= '0;
    end else begin
      drive_pin <= next_pin;
    end
  end

  // Checks
  sequence s_word_commit;
    rx_valid && byte_idx == 3'h3 && reg_addr == OFS_PHASE;
  endsequence
  sequence s_hi_fetch;
    tx_req && !rd_lo && !bus_start;
  endsequence

  a_single_drive: assert property (
    !driver_mode_select |=> ls_q == '0)
    else $error("low-side active in single mode");
  a_dual_drive: assert property (
    driver_mode_select |=> ls_q ==
      $past(low_side_gate_signal & active_phase_select))
    else $error("low-side not passed in dual mode");
  a_alert_or: assert property (
    1'b1 |=> alert_b == |($past(alert_pin_b_enables & alert_src)))
    else $error("alert b is not the masked OR");
  a_alert_nvm: assert property (
    fault.nvm && alert_pin_a_enables[17] |=> alert_a)
    else $error("nvm fault missed on alert a");
  a_alert_short5: assert property (
    fault.hs_short[4] && alert_pin_a_enables[4] |=> alert_a)
    else $error("channel five short missed");
  a_trip_or: assert property (
    1'b1 |=> trip == |($past(trip_enable_set & trip_src)))
    else $error("trip is not the masked OR");
  a_trip_inuv: assert property (
    fault.in_uv && trip_enable_set[15] |=> trip)
    else $error("input undervoltage did not trip");
  a_trip_totss: assert property (
    fault.total_oc_ss && trip_enable_set[1] && !fault.calib |=> trip)
    else $error("soft-start total current did not trip");
  a_phase_gate: assert property (
    1'b1 |=> hs_q == $past(pwm_in & active_phase_select))
    else $error("phase gating wrong");
  a_pin_route: assert property (
    1'b1 |=> drive_pin[1] == $past(pin_map_select ? hs_q[1] : ls_q[0]))
    else $error("pin routing wrong");
  a_word_write: assert property (
    s_word_commit |=> active_phase_select == $past(rx_data[5:0]))
    else $error("phase word write lost");
  a_high_first: assert property (
    s_hi_fetch |=> tx_data == $past(rd_word[15:8]))
    else $error("read did not start with high byte");
  a_unused_quiet: assert property (
    (alert_pin_a_enables & ALERT_USED) == '0 |=> !alert_a)
    else $error("alert a raised with only unassigned positions set");

endmodule

// ### testbench/fmpc_host_model.sv
// Two-wire serial host model for the block's register port
`timescale 1ns/10ps
module fmpc_host_model
  import fmpc_pkg::*;
#(
  parameter logic [6:0] DEV = 7'h71
)(
  input  wire logic core_clk,
  input  wire logic sda,
  output      logic scl,
  output      logic sda_low
);
  logic ack_ok; // Cleared on any missing acknowledge
  // Bus idle at time zero: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_ok = 1'b1;
  end
  // Wait whole cycles, land just after the edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One bit; data moves mid low so it never looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low = ~b;
    wt(2);
    scl = 1'b1;
    wt(4);
    r = sda;
    scl = 1'b0;
  endtask
  // Start: data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    scl = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask
  // Stop: data rises while clock high, bus left released
  task automatic stop();
    wt(2);
    sda_low = 1'b1;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask
  // Byte out, msb first, then the ack slot released
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) ack_ok = 1'b0;
  endtask
  // Byte in; ack (low) asks for more, nack on the last byte ends it
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // address word, then data high, low
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    start();
    put({DEV, 1'b0});
    put(a[15:8]);
    put(a[7:0]);
    put(d[15:8]);
    put(d[7:0]);
    stop();
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    start();
    put({DEV, 1'b0});
    put(a[15:8]);
    put(a[7:0]);
    stop();
    start();
    put({DEV, 1'b1});
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
  endtask
endmodule

// ### testbench/fmpc_fault_mask_phase_config_bench.sv
// Self-checking bench for the fault mask and phase config block
`timescale 1ns/10ps
module fmpc_fault_mask_phase_config_bench;
  import fmpc_pkg::*;
  logic        core_clk, rst_n, sda_out, sda_oe, scl, host_low;
  logic        alert_a, alert_b, trip;
  logic [5:0]  pwm, ls, phase_enable;
  logic [11:0] drive_pin;
  logic [15:0] rdata;
  fmpc_fault_t fault;
  wire logic   sda;
  int          errors, checks_done;
  // Open drain with pull-up: low if either party pulls
  assign sda = ~(sda_oe | host_low);
  fmpc_fault_mask_phase_config fmpc_fault_mask_phase_config_inst (
    .core_clk(core_clk), .rst_n(rst_n), .addr_strap(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .fault(fault), .pwm_in(pwm), .low_side_gate_signal(ls),
    .alert_a(alert_a), .alert_b(alert_b), .trip(trip),
    .phase_enable(phase_enable), .drive_pin(drive_pin));
  fmpc_host_model #(.DEV(SLAVE_BASE | 7'h01)) fmpc_host_model_inst (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(host_low));
  // Compare and tally
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset values, an unmapped read and acks
  task automatic t_reset();
    fmpc_host_model_inst.rd(OFS_PHASE, rdata);
    check(rdata, {10'h000, PHASE_RST});
    check({10'h000, phase_enable}, 16'h003f);
    fmpc_host_model_inst.rd(OFS_TRIP, rdata);
    check(rdata, TRIP_RST);
    fmpc_host_model_inst.rd(16'h0200, rdata);
    check(rdata, 16'h0000);
    check({15'h0000, fmpc_host_model_inst.ack_ok}, 16'h0001);
    check({15'h0000, sda_out}, 16'h0000);
    $display("test reset done");
  endtask
  // Alert masks: unused bits, independence, bit order
  task automatic t_alert();
    fault = '1;
    fmpc_host_model_inst.wr(OFS_ALRTA_L, 16'h0004);
    check({15'h0000, alert_a}, 16'h0000);
    fault = '0;
    fault.nvm = 1'b1;
    fmpc_host_model_inst.wr(OFS_ALRTB_H, 16'h0002);
    check({15'h0000, alert_b}, 16'h0001);
    check({15'h0000, alert_a}, 16'h0000);
    fault = '0;
    fault.hs_short = 6'h08;
    fmpc_host_model_inst.wr(OFS_ALRTA_L, 16'hfffb);
    check({15'h0000, alert_a}, 16'h0000);
    fault.hs_short = 6'h04;
    fmpc_host_model_inst.wt(3);
    check({15'h0000, alert_a}, 16'h0001);
    fmpc_host_model_inst.rd(OFS_ALRTA_L, rdata);
    check(rdata, 16'hfffb);
    $display("test alert done");
  endtask
  // Trip mask: unused bit, channel six absent, field positions
  task automatic t_trip();
    fault = '1;
    fmpc_host_model_inst.wr(OFS_TRIP, 16'h0008);
    check({15'h0000, trip}, 16'h0000);
    fault = '0;
    fault.hs_short = 6'h20;
    fmpc_host_model_inst.wr(OFS_TRIP, 16'hffff);
    check({15'h0000, trip}, 16'h0000);
    fault.hs_short = 6'h00;
    fault.total_oc_ss = 1'b1;
    fmpc_host_model_inst.wr(OFS_TRIP, 16'h0002);
    check({15'h0000, trip}, 16'h0001);
    fault.phase_oc_ss = 1'b1;
    fault.total_oc_ss = 1'b0;
    fmpc_host_model_inst.wr(OFS_TRIP, 16'h0400);
    check({15'h0000, trip}, 16'h0001);
    $display("test trip done");
  endtask
  // Every legal phase count, contiguous from phase one
  task automatic t_phase();
    logic [5:0] v;
    for (int n = 2; n <= 6; n++) begin
      v = 6'((1 << n) - 1);
      fmpc_host_model_inst.wr(OFS_PHASE, {10'h000, v});
      check({10'h000, phase_enable}, {10'h000, v});
    end
    // Legal selector, soft-start phase current tripping, alerts quiet
    fmpc_host_model_inst.rd(OFS_STATUS, rdata);
    check(rdata, 16'h000c);
    $display("test phase done");
  endtask
  // Drive mode and pin map with all six phases active, only phase one driven
  task automatic t_drive();
    pwm = 6'h01;
    ls = 6'h01;
    fmpc_host_model_inst.wr(OFS_MODE, 16'h0000);
    check({4'h0, drive_pin}, 16'h0001);
    fmpc_host_model_inst.wr(OFS_MODE, 16'h0001);
    check({4'h0, drive_pin}, 16'h0003);
    fmpc_host_model_inst.wr(OFS_PINMAP, 16'h0001);
    check({4'h0, drive_pin}, 16'h0041);
    $display("test drive done");
  endtask
  // Clock at 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard at 1 ms, over twice the expected run
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  // Reset two cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    fault = '0;
    pwm = 6'h00;
    ls = 6'h00;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_alert();
    t_trip();
    t_phase();
    t_drive();
    stop_test();
  end
endmodule
